// ===== core/pic_defs.svh
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PIC_IDX_CMP_WORD   14'h0fde
`define PIC_IDX_CMP_LOW    14'h0fdf
`define PIC_IDX_IN_CTRL    14'h0fe0
`define PIC_IDX_NOISE      14'h0fe1
`define PIC_IDX_TIMER_CTRL 14'h0fe2
`define PIC_IDX_STATUS     14'h0fe3
`define PIC_IDX_MASK       14'h0fe4
`define PIC_IDX_COUNT      14'h0fe5

// ==========================================================
// Field positions in the timer control register
`define PIC_BIT_POSITION_COMPARE_ENABLE       0
`define PIC_BIT_CCIE       4
`define PIC_BIT_CCFLAG     5

// ==========================================================
// Reset values
`define PIC_RST_IN_CTRL    8'h00
`define PIC_RST_NOISE      6'h00
`define PIC_RST_CMP        16'hffff
`define PIC_RST_MASK       4'h0

// ==========================================================
// Timing: shortest filter counter width in bits
`define PIC_NOISE_MIN_BITS 32'd2

`endif

// ===== core/pic_noise_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.svh"

module pic_noise_filter #(
	parameter int CNT_W = 5
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       pinIn,
	input  wire logic       filterOn,
	input  wire logic [1:0] widthSel,
	output logic            pinOut
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             level_q;
	logic             level_d;
	logic [CNT_W-1:0] limit;

	// ==========================================================
	// Counter runs while the pin differs from the accepted level
	always_comb begin
		limit   = CNT_W'((32'd1 << (32'(widthSel) + `PIC_NOISE_MIN_BITS)) - 32'd1);
		cnt_d   = '0;
		level_d = level_q;
		if (!filterOn) begin
			level_d = pinIn;
		end else if (pinIn != level_q) begin
			if (cnt_q == limit) begin
				level_d = pinIn;
			end else begin
				cnt_d = cnt_q + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end

	assign pinOut = level_q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_filter_bypass: assert property (!filterOn |=> pinOut == $past(pinIn))
		else $error("bypassed pin not passed through");
	a_filter_reject: assert property (
		filterOn && $past(filterOn) && $changed(pinOut)
		|-> $past(pinIn, 2) == pinOut && $past(pinIn, 4) == pinOut)
		else $error("short pulse accepted by filter");

endmodule
`default_nettype wire

// ===== core/pic_pkg.sv
package pic_pkg;

	typedef enum logic [1:0] {
		POL_STOP = 2'b00,
		POL_RISE = 2'b01,
		POL_FALL = 2'b10,
		POL_BOTH = 2'b11
	} pic_pol_e;

	typedef struct packed {
		pic_pol_e   polarity;
		logic [2:0] noiseEn;
		logic [2:0] edgeEn;
	} pic_in_ctrl_s;

	typedef struct packed {
		logic        write;
		logic [13:0] idx;
	} pic_bus_req_s;

endpackage

// ===== core/pic_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.svh"

// Notes on behaviour
// - Detection fires only on the edge kind chosen by the polarity field.
// - Polarity 0 stops, 1 rising, 2 falling, 3 both; resets to 0.
// - Filter enable per pin routes it through the filter, else bypass.
// - Filter counter of 2 to 5 bits starts when the new level appears.
// - New level accepted only once the counter overflows; short pulses dropped.
// - Filtered pin gives no detection while the internal clock is stopped.
// - Each pin detects edges only while its edge enable bit is one.
// - Compare value equal to timer count clears the count to zero.
// - A match sets the compare-clear flag; enabled flag requests interrupt.
// - A freshly loaded value equal to the count waits for the next arrival.
// - Compare-clear interrupt is high only while flag and enable are one.
// - Writing zero clears the compare-clear flag; writing one keeps it.
module pic_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [2:0]  positionInputPins,
	input  wire logic        clockStopped,
	input  wire logic        timerRun,
	output logic      [2:0]  posDetect,
	output logic      [15:0] timerCount,
	output logic             positionCompareEnable,
	output logic             compareClearIrq,
	output logic             irq
);

	// ==========================================================
	// Bus slave
	pic_pkg::pic_bus_req_s req_q;
	pic_pkg::pic_bus_req_s req_d;
	logic                  dph_q;
	logic                  dph_d;
	logic                  wrEn;
	logic                  rdEn;

	// Only word transfers are expected; hsize is not checked
	always_comb begin
		dph_d = hsel && hready && htrans[1];
		req_d = req_q;
		if (dph_d) begin
			req_d.write = hwrite;
			req_d.idx   = haddr[15:2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dph_q <= 1'b0;
			req_q <= '0;
		end else begin
			dph_q <= dph_d;
			req_q <= req_d;
		end
	end

	assign wrEn      = dph_q && req_q.write;
	assign rdEn      = dph_q && !req_q.write;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	function automatic logic hitIdx(input logic en, input logic [13:0] idx,
			input logic [13:0] want);
		hitIdx = en && (idx == want);
	endfunction

	// ==========================================================
	// Position inputs: synchroniser, filter, edge detection
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] filtLvl;
	logic [2:0] prevLvl_q;
	logic [2:0] prevLvl_d;
	logic [2:0] det_q;
	logic [2:0] det_d;
	logic [2:0] pinValid;
	logic [5:0] noise_q;
	logic [5:0] noise_d;
	pic_pkg::pic_in_ctrl_s inCtrl_q;
	pic_pkg::pic_in_ctrl_s inCtrl_d;

	function automatic logic edgeHit(input pic_pkg::pic_pol_e pol, input logic prev,
			input logic cur);
		case (pol)
			pic_pkg::POL_RISE: edgeHit = !prev && cur;
			pic_pkg::POL_FALL: edgeHit = prev && !cur;
			pic_pkg::POL_BOTH: edgeHit = prev != cur;
			default:           edgeHit = 1'b0;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gPin
			pic_noise_filter #(
				.CNT_W(5)
			) uFilter (
				.clk     (clk),
				.rst     (rst),
				.pinIn   (sync2_q[g]),
				.filterOn(inCtrl_q.noiseEn[g]),
				.widthSel(noise_q[2*g+1 -: 2]),
				.pinOut  (filtLvl[g])
			);
			// Filter has no clock in stop modes, so its output is untrusted
			assign pinValid[g] = !(inCtrl_q.noiseEn[g] && clockStopped);
		end
	endgenerate

	always_comb begin
		prevLvl_d = prevLvl_q;
		det_d     = '0;
		for (int i = 0; i < 3; i++) begin
			if (pinValid[i]) begin
				prevLvl_d[i] = filtLvl[i];
				det_d[i] = inCtrl_q.edgeEn[i]
					&& edgeHit(inCtrl_q.polarity, prevLvl_q[i], filtLvl[i]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			prevLvl_q <= '0;
			det_q     <= '0;
		end else begin
			sync1_q   <= positionInputPins;
			sync2_q   <= sync1_q;
			prevLvl_q <= prevLvl_d;
			det_q     <= det_d;
		end
	end

	assign posDetect = det_q;

	// ==========================================================
	// Compare-clear and timer count
	logic [15:0] cmpVal_q;
	logic [15:0] cmpVal_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic        armed_q;
	logic        armed_d;
	logic        ccFlag_q;
	logic        ccFlag_d;
	logic        ccIe_q;
	logic        ccIe_d;
	logic        position_compare_enable_q;
	logic        position_compare_enable_d;
	logic        match;
	logic        cmpLoad;

	assign match = armed_q && (count_q == cmpVal_q);

	always_comb begin
		cmpVal_d = cmpVal_q;
		inCtrl_d = inCtrl_q;
		noise_d  = noise_q;
		ccIe_d   = ccIe_q;
		position_compare_enable_d   = position_compare_enable_q;
		ccFlag_d = ccFlag_q;
		cmpLoad  = 1'b0;
		if (hitIdx(wrEn, req_q.idx, `PIC_IDX_CMP_WORD)) begin
			cmpVal_d = hwdata[15:0];
			cmpLoad  = 1'b1;
		end
		if (hitIdx(wrEn, req_q.idx, `PIC_IDX_CMP_LOW)) begin
			cmpVal_d[7:0] = hwdata[7:0];
			cmpLoad       = 1'b1;
		end
		if (hitIdx(wrEn, req_q.idx, `PIC_IDX_IN_CTRL)) begin
			inCtrl_d = pic_pkg::pic_in_ctrl_s'(hwdata[7:0]);
		end
		if (hitIdx(wrEn, req_q.idx, `PIC_IDX_NOISE)) begin
			noise_d = hwdata[5:0];
		end
		if (hitIdx(wrEn, req_q.idx, `PIC_IDX_TIMER_CTRL)) begin
			position_compare_enable_d = hwdata[`PIC_BIT_POSITION_COMPARE_ENABLE];
			ccIe_d = hwdata[`PIC_BIT_CCIE];
			if (!hwdata[`PIC_BIT_CCFLAG]) begin
				ccFlag_d = 1'b0;
			end
		end
		// Set wins over a clear in the same cycle
		if (match) begin
			ccFlag_d = 1'b1;
		end
		// Loading disarms, so an equal count at load time does not fire
		if (cmpLoad || match) begin
			armed_d = 1'b0;
		end else begin
			armed_d = armed_q || (count_q != cmpVal_q);
		end
		if (match) begin
			count_d = 16'h0000;
		end else if (timerRun) begin
			count_d = count_q + 16'h0001;
		end else begin
			count_d = count_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmpVal_q <= `PIC_RST_CMP;
			inCtrl_q <= pic_pkg::pic_in_ctrl_s'(`PIC_RST_IN_CTRL);
			noise_q  <= `PIC_RST_NOISE;
			count_q  <= '0;
			armed_q  <= 1'b0;
			ccFlag_q <= 1'b0;
			ccIe_q   <= 1'b0;
			position_compare_enable_q   <= 1'b0;
		end else begin
			cmpVal_q <= cmpVal_d;
			inCtrl_q <= inCtrl_d;
			noise_q  <= noise_d;
			count_q  <= count_d;
			armed_q  <= armed_d;
			ccFlag_q <= ccFlag_d;
			ccIe_q   <= ccIe_d;
			position_compare_enable_q   <= position_compare_enable_d;
		end
	end

	assign timerCount            = count_q;
	assign positionCompareEnable = position_compare_enable_q;
	assign compareClearIrq       = ccFlag_q && ccIe_q;

	// ==========================================================
	// Interrupt status and mask
	logic [3:0] status_q;
	logic [3:0] status_d;
	logic [3:0] mask_q;
	logic [3:0] mask_d;

	always_comb begin
		status_d = status_q;
		mask_d   = mask_q;
		if (hitIdx(rdEn, req_q.idx, `PIC_IDX_STATUS)) begin
			status_d = '0;
		end
		status_d = status_d | {det_d, match};
		if (hitIdx(wrEn, req_q.idx, `PIC_IDX_MASK)) begin
			mask_d = hwdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= '0;
			mask_q   <= `PIC_RST_MASK;
		end else begin
			status_q <= status_d;
			mask_q   <= mask_d;
		end
	end

	assign irq = |(status_q & mask_q);

	// ==========================================================
	// Read data, driven in the data phase from register state
	always_comb begin
		hrdata = '0;
		if (rdEn) begin
			case (req_q.idx)
				`PIC_IDX_CMP_WORD:   hrdata[15:0] = cmpVal_q;
				`PIC_IDX_CMP_LOW:    hrdata[7:0]  = cmpVal_q[7:0];
				`PIC_IDX_IN_CTRL:    hrdata[7:0]  = inCtrl_q;
				`PIC_IDX_NOISE:      hrdata[5:0]  = noise_q;
				`PIC_IDX_TIMER_CTRL: begin
					hrdata[`PIC_BIT_POSITION_COMPARE_ENABLE]   = position_compare_enable_q;
					hrdata[`PIC_BIT_CCIE]   = ccIe_q;
					hrdata[`PIC_BIT_CCFLAG] = ccFlag_q;
				end
				`PIC_IDX_STATUS:     hrdata[3:0]  = status_q;
				`PIC_IDX_MASK:       hrdata[3:0]  = mask_q;
				`PIC_IDX_COUNT:      hrdata[15:0] = count_q;
				default:             hrdata = '0;
			endcase
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence sCmpWordWrite;
		wrEn && req_q.idx == `PIC_IDX_CMP_WORD;
	endsequence

	sequence sFlagClearWrite;
		wrEn && req_q.idx == `PIC_IDX_TIMER_CTRL && !hwdata[`PIC_BIT_CCFLAG] && !match;
	endsequence

	a_match_clears_count: assert property (match |=> count_q == 16'h0000)
		else $error("count not cleared on match");
	a_match_sets_flag: assert property (match |=> ccFlag_q ##0 status_q[0])
		else $error("flag not set on match");
	a_load_no_match: assert property (cmpLoad |=> !match)
		else $error("match right after load");
	a_word_atomic: assert property (sCmpWordWrite |=> cmpVal_q == $past(hwdata[15:0]))
		else $error("word write not taken whole");
	a_flag_write_zero: assert property (sFlagClearWrite |=> !ccFlag_q)
		else $error("flag not cleared by zero write");
	a_cc_irq_gate: assert property (match && ccIe_q && !wrEn |=> compareClearIrq)
		else $error("irq not raised on enabled match");
	a_edge_gate: assert property ((det_q & ~$past(inCtrl_q.edgeEn)) == 3'b000)
		else $error("detection on disabled pin");
	a_pol_stop: assert property ($past(inCtrl_q.polarity) == pic_pkg::POL_STOP
		|-> det_q == 3'b000)
		else $error("detection while polarity stopped");
	a_rise_only: assert property ($past(inCtrl_q.polarity) == pic_pkg::POL_RISE
		|-> (det_q & ~$past(filtLvl)) == 3'b000)
		else $error("detection on wrong edge");
	a_stop_invalid: assert property ($past(clockStopped)
		|-> (det_q & $past(inCtrl_q.noiseEn)) == 3'b000)
		else $error("filtered pin detected while stopped");

endmodule
`default_nettype wire

// ===== tb/pic_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Position sensor model
// Push-pull sensor lines: a level always stands, there is no released state
module pic_pin_model (
	input  wire logic       clk,
	output logic      [2:0] pins
);
	initial pins = 3'h0;

	task automatic setPin(input int p, input logic lvl);
		@(posedge clk);
		pins[p] <= lvl;
	endtask

	// High for len cycles, then low again
	task automatic pulse(input int p, input int len);
		setPin(p, 1'b1);
		repeat (len - 1) @(posedge clk);
		setPin(p, 1'b0);
	endtask
endmodule

`default_nettype wire

// ===== tb/pic_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.svh"

module pic_top_tb_top;
	logic        clk, rst, hsel, hwrite, clockStopped, timerRun, rdPend;
	logic        hreadyout, hresp, pce, ccIrq, irq;
	logic [31:0] haddr, hwdata, hrdata, lfsr;
	logic [15:0] timerCount, cmp;
	logic [2:0]  hsize, pins, posDetect;
	logic [1:0]  htrans;
	logic [31:0] expQ[$];
	int          n_fail, n_compared, k;
	pic_pkg::pic_in_ctrl_s ctl;
	logic [2:0]  seenDet;

	pic_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.positionInputPins(pins), .clockStopped(clockStopped), .timerRun(timerRun),
		.posDetect(posDetect), .timerCount(timerCount),
		.positionCompareEnable(pce), .compareClearIrq(ccIrq), .irq(irq));
	pic_pin_model pin_u (.clk(clk), .pins(pins));

	// ==========================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ==========================================
	// Bus master: the master never assumes a wait count
	task automatic waitRdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			n_fail++;
			end_sim();
		end
	endtask

	// Reads note d as the expected data
	task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {16'h0000, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		waitRdy();
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h00000000;
		if (!wr) begin
			expQ.push_back(d);
			rdPend <= 1'b1;
		end
		waitRdy();
		rdPend <= 1'b0;
	endtask

	// Read data taken at the closing edge of the data phase
	always @(posedge clk) begin
		if (rdPend && hreadyout) begin
			check(hrdata, expQ.pop_front());
			check(hresp, 32'h0);
		end
	end

	// Detection pulses last one cycle, so keep a sticky record of them
	always @(posedge clk) begin
		seenDet <= rst ? 3'b000 : (seenDet | posDetect);
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================
	// Main sequence
	initial begin
		{rst, hsel, hwrite, clockStopped, timerRun, rdPend} = 6'b100000;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
		{n_fail, n_compared} = 0;
		lfsr = 32'h00015a21;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		xfer(1'b0, `PIC_IDX_IN_CTRL, 32'h0);
		xfer(1'b0, `PIC_IDX_TIMER_CTRL, 32'h0);
		xfer(1'b0, `PIC_IDX_CMP_WORD, 32'hffff);
		xfer(1'b1, 14'h0fe6, 32'hffffffff);
		xfer(1'b0, 14'h0fe6, 32'h0);
		lfsr = lfsrNext(lfsr);
		xfer(1'b1, `PIC_IDX_CMP_WORD, {16'h0, lfsr[15:0]});
		xfer(1'b0, `PIC_IDX_CMP_WORD, {16'h0, lfsr[15:0]});
		xfer(1'b1, `PIC_IDX_CMP_LOW, {24'h0, lfsr[23:16]});
		xfer(1'b0, `PIC_IDX_CMP_WORD, {16'h0, lfsr[15:8], lfsr[23:16]});
		// Polarity: a held level separates rising from falling
		ctl = '{pic_pkg::POL_STOP, 3'b000, 3'b111};
		for (int p = 0; p < 4; p++) begin
			ctl.polarity = pic_pkg::pic_pol_e'(p);
			xfer(1'b1, `PIC_IDX_IN_CTRL, {24'h0, ctl});
			xfer(1'b0, `PIC_IDX_IN_CTRL, {24'h0, ctl});
			xfer(1'b0, `PIC_IDX_STATUS, 32'h0);
			pin_u.setPin(0, 1'b1);
			repeat (6) @(posedge clk);
			xfer(1'b0, `PIC_IDX_STATUS, p[0] ? 32'h2 : 32'h0);
			pin_u.setPin(0, 1'b0);
			repeat (6) @(posedge clk);
			xfer(1'b0, `PIC_IDX_STATUS, p[1] ? 32'h2 : 32'h0);
		end
		xfer(1'b1, `PIC_IDX_IN_CTRL, 32'hc1);
		pin_u.pulse(1, 4);
		repeat (6) @(posedge clk);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h0);
		xfer(1'b1, `PIC_IDX_MASK, 32'h2);
		pin_u.pulse(0, 4);
		repeat (6) @(posedge clk);
		#1 check(irq, 32'h1);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h2);
		#1 check(irq, 32'h0);
		check(seenDet, 32'h1);
		// Filter on pin 2: short pulse dropped, long one kept
		xfer(1'b1, `PIC_IDX_IN_CTRL, 32'he4);
		for (int w = 0; w < 4; w++) begin
			xfer(1'b1, `PIC_IDX_NOISE, {26'h0, w[1:0], 4'h0});
			pin_u.pulse(2, (1 << (w + 2)) / 2);
			repeat ((1 << (w + 2)) + 6) @(posedge clk);
			xfer(1'b0, `PIC_IDX_STATUS, 32'h0);
			pin_u.pulse(2, (1 << (w + 2)) + 4);
			repeat ((1 << (w + 2)) + 6) @(posedge clk);
			xfer(1'b0, `PIC_IDX_STATUS, 32'h8);
		end
		clockStopped <= 1'b1;
		pin_u.pulse(2, 40);
		repeat (40) @(posedge clk);
		clockStopped <= 1'b0;
		xfer(1'b0, `PIC_IDX_STATUS, 32'h0);
		xfer(1'b1, `PIC_IDX_IN_CTRL, 32'hc4);
		pin_u.pulse(2, 3);
		repeat (6) @(posedge clk);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h8);
		// Compare clear; edge enables were set before compare enable
		xfer(1'b1, `PIC_IDX_TIMER_CTRL, 32'h11);
		#1 check(pce, 32'h1);
		xfer(1'b1, `PIC_IDX_MASK, 32'h1);
		lfsr = lfsrNext(lfsr);
		cmp = {11'h0, lfsr[4:0]} + 16'h8;
		xfer(1'b1, `PIC_IDX_CMP_WORD, {16'h0, cmp});
		timerRun <= 1'b1;
		for (k = 0; k < 300 && ccIrq !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k >= 300) begin
			n_fail++;
			end_sim();
		end
		timerRun <= 1'b0;
		check(timerCount, 32'h0);
		check(irq, 32'h1);
		xfer(1'b0, `PIC_IDX_TIMER_CTRL, 32'h31);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h1);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h0);
		#1 check(irq, 32'h0);
		xfer(1'b1, `PIC_IDX_TIMER_CTRL, 32'h31);
		xfer(1'b0, `PIC_IDX_TIMER_CTRL, 32'h31);
		xfer(1'b1, `PIC_IDX_TIMER_CTRL, 32'h11);
		xfer(1'b0, `PIC_IDX_TIMER_CTRL, 32'h11);
		#1 check(ccIrq, 32'h0);
		// Loaded value equal to the held count must not match
		xfer(1'b1, `PIC_IDX_CMP_WORD, 32'h0);
		repeat (5) @(posedge clk);
		xfer(1'b0, `PIC_IDX_TIMER_CTRL, 32'h11);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h0);
		xfer(1'b1, `PIC_IDX_TIMER_CTRL, 32'h01);
		xfer(1'b1, `PIC_IDX_CMP_WORD, 32'h3);
		timerRun <= 1'b1;
		repeat (8) @(posedge clk);
		timerRun <= 1'b0;
		xfer(1'b0, `PIC_IDX_TIMER_CTRL, 32'h21);
		#1 check(ccIrq, 32'h0);
		xfer(1'b0, `PIC_IDX_STATUS, 32'h1);
		check(seenDet, 32'h5);
		end_sim();
	end
endmodule

`default_nettype wire
